// *** core/asf_defs.vh ***
// Constants for the ALU condition flag register.
`ifndef ASF_DEFS_VH
`define ASF_DEFS_VH
`define ASF_ADDR_FLAGS 8'h00
`define ASF_BIT_NEG 4
`define ASF_BIT_WRAP 3
`define ASF_BIT_ZERO 2
`define ASF_BIT_NIB 1
`define ASF_BIT_CARRY 0
`define ASF_IMPL_MASK 8'h1F
`define ASF_FLAGS_RESET 5'h00
`define ASF_OP_NONE 4'h0
`define ASF_OP_ADD 4'h1
`define ASF_OP_SUB 4'h2
`define ASF_OP_LOGIC 4'h3
`define ASF_OP_CLEAR 4'h4
`define ASF_OP_ROT_RIGHT 4'h5
`define ASF_OP_ROT_LEFT 4'h6
`define ASF_OP_MOVE_NZ 4'h7
`endif

// *** core/asf_flags.v ***
// ALU condition flag register with flag logic and a register port.
`timescale 1ns/1ps
`include "asf_defs.vh"
module asf_flags (
  input wire clock,
  input wire rst_b,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  input wire op_valid,
  input wire [3:0] op_class,
  input wire [7:0] op_a,
  input wire [7:0] op_b,
  input wire op_carry_in,
  input wire op_to_flags,
  output reg [7:0] op_result,
  output reg [4:0] flags_out
);

  wire cls_add;
  wire cls_sub;
  wire cls_arith;
  wire cls_nz;
  wire cls_clear;
  wire cls_rot_right;
  wire cls_rot_left;
  wire cls_rot;
  wire cls_other;
  wire reg_hit_wr;
  wire reg_hit_rd;
  wire dest_store;
  wire reg_store;
  wire ovf_signed;
  wire nib_carry;
  wire byte_carry;
  wire [7:0] addend;
  wire [7:0] sum_bits;
  wire [8:0] carry_chain;
  wire [7:0] rot_result;
  wire rot_nib;
  wire rot_carry;
  wire [7:0] read_word;
  wire [4:0] flags_next;
  reg [4:0] flags_reg;
  reg [4:0] own_mask;
  reg [4:0] flag_val;
  reg [7:0] result_next;

  // The execution core drives op_class; op_a is the source register value and op_b the
  // second operand. A subtract computes op_a minus op_b.
  asf_class_decode asf_class_decode_inst (
    .op_valid(op_valid),
    .op_class(op_class),
    .cls_add(cls_add),
    .cls_sub(cls_sub),
    .cls_nz(cls_nz),
    .cls_clear(cls_clear),
    .cls_rot_right(cls_rot_right),
    .cls_rot_left(cls_rot_left),
    .cls_other(cls_other)
  );

  assign cls_arith = cls_add || cls_sub;
  assign cls_rot = cls_rot_right || cls_rot_left;
  assign reg_hit_wr = reg_write && (reg_addr == `ASF_ADDR_FLAGS);
  assign reg_hit_rd = reg_read && (reg_addr == `ASF_ADDR_FLAGS);

  // Subtraction adds the inverted operand with a carry in of one, so a set carry or nibble
  // carry afterwards means that no borrow was taken.
  assign addend = cls_sub ? ~op_b : op_b;

  asf_ripple_add asf_ripple_add_inst (
    .augend(op_a),
    .addend(addend),
    .carry_in(cls_sub),
    .sum(sum_bits),
    .carries(carry_chain)
  );

  // Signed overflow is a carry into the sign bit without a carry out of it, or the reverse.
  assign ovf_signed = carry_chain[8] ^ carry_chain[7];
  assign nib_carry = carry_chain[4];
  assign byte_carry = carry_chain[8];

  asf_rotator asf_rotator_inst (
    .rot_right(cls_rot_right),
    .rot_left(cls_rot_left),
    .source(op_a),
    .carry_in(op_carry_in),
    .result(rot_result),
    .nib_out(rot_nib),
    .carry_out(rot_carry)
  );

  always @* begin
    result_next = 8'h00;
    if (op_valid) begin
      case (op_class)
        `ASF_OP_ADD, `ASF_OP_SUB: begin
          result_next = sum_bits;
        end
        `ASF_OP_LOGIC, `ASF_OP_MOVE_NZ: begin
          result_next = op_b;
        end
        `ASF_OP_ROT_RIGHT, `ASF_OP_ROT_LEFT: begin
          result_next = rot_result;
        end
        `ASF_OP_CLEAR: begin
          result_next = 8'h00;
        end
        default: begin
          result_next = op_b;
        end
      endcase
    end
  end

  // Bits that the current operation moves belong to the flag logic in this cycle.
  always @* begin
    own_mask = 5'h00;
    own_mask[`ASF_BIT_NEG] = cls_arith || cls_nz;
    own_mask[`ASF_BIT_WRAP] = cls_arith;
    own_mask[`ASF_BIT_ZERO] = cls_arith || cls_nz || cls_clear;
    own_mask[`ASF_BIT_NIB] = cls_arith || cls_rot;
    own_mask[`ASF_BIT_CARRY] = cls_arith || cls_rot;
  end

  // A clear leaves a zero result, so the zero test below also serves it.
  always @* begin
    flag_val = 5'h00;
    flag_val[`ASF_BIT_NEG] = result_next[7];
    flag_val[`ASF_BIT_WRAP] = ovf_signed;
    flag_val[`ASF_BIT_ZERO] = (result_next == 8'h00);
    flag_val[`ASF_BIT_NIB] = cls_rot ? rot_nib : nib_carry;
    flag_val[`ASF_BIT_CARRY] = cls_rot ? rot_carry : byte_carry;
  end

  // Any class that moves one of the five flags keeps its own result off all of them, which
  // is why a result aimed at this register may read back other than intended.
  assign dest_store = cls_other && op_to_flags;
  // A core operation wins over a register port write in the same cycle.
  assign reg_store = !op_valid && reg_hit_wr;

  // Each bit takes, in falling priority, flag logic, a stored result, a port write or itself.
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_flag_bit
      assign flags_next[gi] = own_mask[gi] ? flag_val[gi] :
                              dest_store ? result_next[gi] :
                              reg_store ? reg_wdata[gi] :
                              flags_reg[gi];
    end
  endgenerate

  // Power-on value is unknown by definition; zero is used so simulation stays defined.
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      flags_reg <= `ASF_FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // The copy on flags_out lets the core see the flags without a register read.
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      flags_out <= `ASF_FLAGS_RESET;
      op_result <= 8'h00;
    end else begin
      flags_out <= flags_next;
      op_result <= result_next;
    end
  end

  // The three top bits have no storage and always read as zero.
  assign read_word = {3'h0, flags_reg} & `ASF_IMPL_MASK;

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_hit_rd) begin
      reg_rdata <= read_word;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// Turns the class code into one strobe per class; codes with no meaning count as other.
module asf_class_decode (
  input wire op_valid,
  input wire [3:0] op_class,
  output reg cls_add,
  output reg cls_sub,
  output reg cls_nz,
  output reg cls_clear,
  output reg cls_rot_right,
  output reg cls_rot_left,
  output reg cls_other
);

  always @* begin
    cls_add = 1'b0;
    cls_sub = 1'b0;
    cls_nz = 1'b0;
    cls_clear = 1'b0;
    cls_rot_right = 1'b0;
    cls_rot_left = 1'b0;
    cls_other = 1'b0;
    if (op_valid) begin
      case (op_class)
        `ASF_OP_NONE: begin
          cls_other = 1'b1;
        end
        `ASF_OP_ADD: begin
          cls_add = 1'b1;
        end
        `ASF_OP_SUB: begin
          cls_sub = 1'b1;
        end
        `ASF_OP_LOGIC, `ASF_OP_MOVE_NZ: begin
          cls_nz = 1'b1;
        end
        `ASF_OP_CLEAR: begin
          cls_clear = 1'b1;
        end
        `ASF_OP_ROT_RIGHT: begin
          cls_rot_right = 1'b1;
        end
        `ASF_OP_ROT_LEFT: begin
          cls_rot_left = 1'b1;
        end
        default: begin
          cls_other = 1'b1;
        end
      endcase
    end
  end

endmodule

// Eight-bit ripple adder that exposes every carry, so the nibble and signed flags need no
// second adder beside it.
module asf_ripple_add (
  input wire [7:0] augend,
  input wire [7:0] addend,
  input wire carry_in,
  output wire [7:0] sum,
  output wire [8:0] carries
);

  assign carries[0] = carry_in;

  genvar bi;
  generate
    for (bi = 0; bi < 8; bi = bi + 1) begin : g_sum_bit
      assign sum[bi] = augend[bi] ^ addend[bi] ^ carries[bi];
      assign carries[bi + 1] = (augend[bi] & addend[bi]) | (augend[bi] & carries[bi]) |
                               (addend[bi] & carries[bi]);
    end
  endgenerate

endmodule

// Rotates through the carry; the bit that leaves the byte becomes the new carry, and the
// nibble carry takes the bit that crosses the nibble boundary.
module asf_rotator (
  input wire rot_right,
  input wire rot_left,
  input wire [7:0] source,
  input wire carry_in,
  output reg [7:0] result,
  output reg nib_out,
  output reg carry_out
);

  always @* begin
    result = source;
    nib_out = 1'b0;
    carry_out = 1'b0;
    if (rot_right) begin
      result = {carry_in, source[7:1]};
      nib_out = source[4];
      carry_out = source[0];
    end else if (rot_left) begin
      result = {source[6:0], carry_in};
      nib_out = source[3];
      carry_out = source[7];
    end
  end

endmodule

// *** bench/asf_core_model.sv ***
// Core model issuing one ALU operation at a time.
`timescale 1ns/1ps
module asf_core_model (
  input wire clock,
  output reg op_valid = 0, op_carry_in = 0, op_to_flags = 0,
  output reg [3:0] op_class = 0,
  output reg [7:0] op_a = 0, op_b = 0
);
  task issue(input [21:0] w);
    @(posedge clock);
    {op_class, op_a, op_b, op_carry_in, op_to_flags, op_valid} <= {w, 1'b1};
    @(posedge clock);
    op_valid <= 1'b0;
  endtask
endmodule

// *** bench/asf_flags_sva.sv ***
// Checker for the ALU condition flag register.
`timescale 1ns/1ps
module asf_flags_chk (
  input wire clock, rst_b, reg_write, reg_read, op_valid,
  input wire [3:0] op_class,
  input wire [7:0] reg_addr, reg_rdata, op_a, op_result,
  input wire [4:0] flags_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire rh = reg_read && !reg_addr;
  wire [3:0] k = op_valid ? op_class : 4'hf;
  wire [4:0] f = flags_out;
  rd_top_a: assert property (reg_rdata[7:5] == 3'h0) else $error("rdata");
  rd_val_a: assert property (rh |=> reg_rdata == $past(f)) else $error("rdata");
  rd_idle_a: assert property (!rh |=> !reg_rdata) else $error("rdata");
  clr_zero_a: assert property (k == 4'h4 |=> f == ($past(f) | 5'h04)) else $error("clr");
  nz_flags_a: assert property (k[3:1] == 3'h1 |=>
    f[4] == op_result[7] && f[2] == !op_result) else $error("nz");
  keep_flags_a: assert property (k == 4'hf && !reg_write |=> $stable(f)) else $error("f");
  rot_right_a: assert property (k == 4'h5 |=>
    f[1:0] == {$past(op_a[4]), $past(op_a[0])}) else $error("rotate");
  rot_left_a: assert property (k == 4'h6 |=>
    f[1:0] == {$past(op_a[3]), $past(op_a[7])}) else $error("rotate");
  cover property (k == 4'h4);
  cover property (rh);
  cover property (k == 4'h6);
endmodule
bind asf_flags asf_flags_chk asf_flags_chk_inst (.*);

// *** bench/test_alu_status_flags.sv ***
// Bench for the ALU condition flag register.
`timescale 1ns/1ps
module test_alu_status_flags;
  reg clock = 0, rst_b = 0, reg_write = 0, reg_read = 0, po = 0, pr = 0;
  reg [7:0] reg_addr = 0, reg_wdata = 0, r;
  reg [4:0] ef = 0;
  reg [12:0] q[$];
  wire op_valid, op_carry_in, op_to_flags;
  wire [3:0] op_class;
  wire [7:0] op_a, op_b, op_result, reg_rdata;
  wire [4:0] flags_out;
  integer err_count = 0, checks_done = 0, seed = 32'h3943;
  asf_flags asf_flags_inst (.*);
  asf_core_model asf_core_model_inst (.*);
  initial forever #2 clock = ~clock;
  task tally_and_finish;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task cmp_op(input [12:0] e, g);
    checks_done++;
    if (e !== g) $display("Error op exp %h got %h", e, g);
    err_count += e !== g;
  endtask
  task cmp_rd(input [7:0] e, g);
    checks_done++;
    if (e !== g) $display("Error rdata exp %h got %h", e, g);
    err_count += e !== g;
  endtask
  always @(posedge clock) {po, pr} <= {op_valid, reg_read};
  always @(negedge clock) begin
    if (po) cmp_op(q.pop_front(), {op_result, flags_out});
    if (pr) cmp_rd(q.pop_front(), reg_rdata);
  end
  // The core passes the carry held before the operation, so issue first.
  task op(input [3:0] c, input [7:0] a, b, input tf);
    reg [8:0] s;
    reg [7:0] m, v;
    asf_core_model_inst.issue({c, a, b, ef[0], tf});
    m = c == 4'h2 ? ~b : b;
    s = a + m + (c == 4'h2);
    v = b;
    case (c)
      1, 2: {v, ef} = {s[7:0], s[7], a[7] == m[7] && s[7] != a[7],
        !s[7:0], a[4] ^ m[4] ^ s[4], s[8]};
      3, 7: {ef[4], ef[2]} = {b[7], !b};
      4: {v, ef[2]} = 9'h001;
      5: {v, ef[1:0]} = {ef[0], a[7:1], a[4], a[0]};
      6: {v, ef[1:0]} = {a[6:0], ef[0], a[3], a[7]};
      0: if (tf) ef = b[4:0];
    endcase
    q.push_back({v, ef});
  endtask
  task bus(input w, input [7:0] ad, d);
    @(posedge clock);
    {reg_write, reg_read, reg_addr, reg_wdata} <= {w, !w, ad, d};
    if (w && !ad) ef = d[4:0];
    if (!w) q.push_back(ad ? 13'h0000 : ef);
    @(posedge clock);
    {reg_write, reg_read} <= 2'h0;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    bus(0, 8'h00, 8'h00);
    bus(1, 8'h00, 8'hff);
    bus(0, 8'h00, 8'h00);
    op(1, 8'h0f, 8'h01, 1);
    op(4, 8'h12, 8'h34, 1);
    repeat (400) begin
      r = $random(seed);
      op(r[2:0], $random(seed), $random(seed), r[3]);
      bus(r[4], r[5], $random(seed));
    end
    repeat (2) @(posedge clock);
    tally_and_finish;
  end
  initial begin
    #40000;
    err_count++;
    tally_and_finish;
  end
endmodule
